/* presettable_down_timer.sv */
`timescale 1ns/100ps
`include "timer_cfg.svh"
module presettable_down_timer
    import timer_pkg::*;
(
    // clock, reset, freeze
    input  wire logic                 ref_clk_in,
    input  wire logic                 reset_n_in,
    input  wire logic                 clk_en_in,
    // apb slave
    input  wire logic                 psel_in,
    input  wire logic                 penable_in,
    input  wire logic                 pwrite_in,
    input  wire logic [7:0]           paddr_in,
    input  wire logic [31:0]          pwdata_in,
    output logic      [31:0]          prdata_out,
    output logic                      pready_out,
    output logic                      pslverr_out,
    // count clock sources, asynchronous
    input  wire logic                 internal_rc_oscillator_in,
    input  wire logic                 low_speed_oscillator_in,
    input  wire logic                 high_speed_oscillator_in,
    input  wire logic                 external_clock_input_in,
    input  wire logic [`NUM_CH-1:0]   event_count_input_in,
    // system state, same clock
    input  wire logic                 debug_mode_in,
    input  wire logic                 sleep_clock_stop_in,
    // events
    output logic      [`NUM_CH-1:0]   underflow_pulse_out,
    output logic      [`NUM_CH-1:0]   irq_out,
    output logic                      serial_master_clock_out
);

    chan_cfg_t   cfg        [`NUM_CH];
    chan_state_t st         [`NUM_CH];
    logic [14:0] prescale   [`NUM_CH];
    logic [`NUM_CH-1:0] uf_q;
    logic        serial_q;
    logic [31:0] rdata_q;

    // three-stage synchronisers for all asynchronous source pins
    logic [`NUM_SYNC-1:0] sync1;
    logic [`NUM_SYNC-1:0] sync2;
    logic [`NUM_SYNC-1:0] sync3;
    logic [`NUM_SYNC-1:0] stable;
    wire  [`NUM_SYNC-1:0] raw_pins = {event_count_input_in, external_clock_input_in,
                                      high_speed_oscillator_in, low_speed_oscillator_in,
                                      internal_rc_oscillator_in};
    wire  [`NUM_SYNC-1:0] agree    = ~(sync2 ^ sync3);
    wire  [`NUM_SYNC-1:0] next_stable = (agree & sync2) | (~agree & stable);
    wire  [`NUM_SYNC-1:0] rise     = next_stable & ~stable;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync1  <= '0;
            sync2  <= '0;
            sync3  <= '0;
            stable <= '0;
        end else if (clk_en_in) begin
            sync1  <= raw_pins;
            sync2  <= sync1;
            sync3  <= sync2;
            stable <= next_stable;
        end
    end

    function automatic logic [14:0] div_mask(input logic [3:0] d);
        div_mask = 15'(~(`ALL_ONES_15 << d));
    endfunction

    // apb decode
    wire       access   = psel_in & penable_in;
    wire       setup    = psel_in & ~penable_in;
    wire [1:0] sel_ch   = paddr_in[6:5];
    wire [2:0] sel_reg  = paddr_in[4:2];
    wire       mapped   = (32'(sel_ch) < `NUM_CH) && (sel_reg <= `REG_LAST) &&
                          (paddr_in[1:0] == 2'b00) && !paddr_in[7];
    wire       wr       = access & pwrite_in & mapped;

    assign pready_out  = 1'b1;
    assign pslverr_out = access & ~mapped;
    assign prdata_out  = rdata_q;

    // read mux, sampled in setup so the data comes from a flip-flop
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        for (int c = 0; c < `NUM_CH; c++) begin
            if (mapped && sel_ch == 2'(c)) begin
                case (sel_reg)
                    `OFS_CLK: begin
                        rd_mux[`BIT_DEBUG_RUN_ENABLE]            = cfg[c].debug_run_enable;
                        rd_mux[`DIV_LSB+3:`DIV_LSB]   = cfg[c].count_clock_divider;
                        rd_mux[1:0]                   = cfg[c].count_clock_source;
                    end
                    `OFS_MOD:  rd_mux[`BIT_ONE_SHOT] = cfg[c].one_shot_select;
                    `OFS_CTL: begin
                        rd_mux[`BIT_RUN]    = st[c].run_control;
                        rd_mux[`BIT_PRESET] = st[c].preset_busy;
                        rd_mux[`BIT_ENABLE] = cfg[c].channel_enable;
                    end
                    `OFS_TR:   rd_mux[15:0] = cfg[c].reload_value;
                    `OFS_TC:   rd_mux[15:0] = st[c].counter_value;
                    `OFS_INTF: rd_mux[`BIT_FLAG] = st[c].underflow_flag;
                    `OFS_INTE: rd_mux[`BIT_IRQ_EN] = cfg[c].underflow_irq_enable;
                    default:   rd_mux = '0;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_q <= '0;
        end else if (clk_en_in && setup) begin
            rdata_q <= rd_mux;
        end
    end

    // per-channel count tick and underflow
    logic [`NUM_CH-1:0] src_edge;
    logic [`NUM_CH-1:0] tick;
    logic [`NUM_CH-1:0] held;
    logic [`NUM_CH-1:0] uf_now;
    // no channel has an event pin, so source three takes the external clock
    wire  [`NUM_CH-1:0] event_ch = `EVENT_CH_MASK;

    wire wr_clk  = wr && sel_reg == `OFS_CLK;
    wire wr_mod  = wr && sel_reg == `OFS_MOD;
    wire wr_ctl  = wr && sel_reg == `OFS_CTL;
    wire wr_tr   = wr && sel_reg == `OFS_TR;
    wire wr_intf = wr && sel_reg == `OFS_INTF;
    wire wr_inte = wr && sel_reg == `OFS_INTE;

    for (genvar c = 0; c < `NUM_CH; c++) begin : g_ch
        wire [14:0] mask     = div_mask(cfg[c].count_clock_divider);
        wire        hit      = (sel_ch == 2'(c));
        wire        ext_src  = (cfg[c].count_clock_source == `SRC_EXTERNAL);
        wire        at_zero  = (st[c].counter_value == `ZERO_COUNT);
        wire        wrap     = ((prescale[c] & mask) == mask);
        wire        load_now = st[c].preset_busy && cfg[c].channel_enable;
        wire        ctl_hit  = hit && wr_ctl;
        wire        clr_flag = hit && wr_intf && pwdata_in[`BIT_FLAG];

        always_comb begin
            case (cfg[c].count_clock_source)
                `SRC_INTERNAL:   src_edge[c] = rise[0];
                `SRC_LOW_SPEED:  src_edge[c] = rise[1];
                `SRC_HIGH_SPEED: src_edge[c] = rise[2];
                `SRC_EXTERNAL:   src_edge[c] = event_ch[c] ? rise[4+c] : rise[3];
                default:         src_edge[c] = 1'b0;
            endcase
        end

        // gating freezes prescaler and counter alike
        assign held[c]   = !cfg[c].channel_enable || sleep_clock_stop_in ||
                           (debug_mode_in && !cfg[c].debug_run_enable);
        // the external source is never divided
        assign tick[c]   = src_edge[c] && !held[c] && (ext_src || wrap);
        assign uf_now[c] = tick[c] && st[c].run_control && at_zero;

        // prescaler advances on every ungated source edge
        always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                prescale[c] <= `ZERO_15;
            end else if (clk_en_in && src_edge[c] && !held[c]) begin
                prescale[c] <= prescale[c] + `ONE_15;
            end
        end

        // software settings
        always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                cfg[c]              <= '0;
                cfg[c].reload_value <= `RESET_COUNT;
            end else if (clk_en_in) begin
                if (hit && wr_clk) begin
                    cfg[c].debug_run_enable    <= pwdata_in[`BIT_DEBUG_RUN_ENABLE];
                    cfg[c].count_clock_divider <= pwdata_in[`DIV_LSB+3:`DIV_LSB];
                    cfg[c].count_clock_source  <= pwdata_in[1:0];
                end
                if (hit && wr_mod) begin
                    cfg[c].one_shot_select <= pwdata_in[`BIT_ONE_SHOT];
                end
                if (ctl_hit) begin
                    cfg[c].channel_enable <= pwdata_in[`BIT_ENABLE];
                end
                if (hit && wr_tr) begin
                    cfg[c].reload_value <= pwdata_in[15:0];
                end
                if (hit && wr_inte) begin
                    cfg[c].underflow_irq_enable <= pwdata_in[`BIT_IRQ_EN];
                end
            end
        end

        // counter and status
        always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                st[c]               <= '0;
                st[c].counter_value <= `RESET_COUNT;
                uf_q[c]             <= 1'b0;
            end else if (clk_en_in) begin
                // preset wins over the underflow reload and the decrement
                if (load_now) begin
                    st[c].counter_value <= cfg[c].reload_value;
                end else if (uf_now[c]) begin
                    st[c].counter_value <= cfg[c].reload_value;
                end else if (tick[c] && st[c].run_control) begin
                    st[c].counter_value <= st[c].counter_value - `ONE_COUNT;
                end
                // a preset stays pending until the channel clock is enabled
                if (ctl_hit && pwdata_in[`BIT_PRESET]) begin
                    st[c].preset_busy <= 1'b1;
                end else if (load_now) begin
                    st[c].preset_busy <= 1'b0;
                end
                // a software write to run overrides the one-shot self-clear
                if (ctl_hit) begin
                    st[c].run_control <= pwdata_in[`BIT_RUN];
                end else if (uf_now[c] && cfg[c].one_shot_select) begin
                    st[c].run_control <= 1'b0;
                end
                // set wins over the write-one clear
                st[c].underflow_flag <= uf_now[c] | (st[c].underflow_flag & ~clr_flag);
                uf_q[c]              <= uf_now[c];
            end
        end
    end

    // the peripheral clock only runs in repeat mode
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            serial_q <= 1'b0;
        end else if (clk_en_in) begin
            serial_q <= uf_now[`SERIAL_CH] && !cfg[`SERIAL_CH].one_shot_select;
        end
    end

    assign underflow_pulse_out     = uf_q;
    assign serial_master_clock_out = serial_q;

    always_comb begin
        for (int c = 0; c < `NUM_CH; c++) begin
            irq_out[c] = st[c].underflow_flag && cfg[c].underflow_irq_enable;
        end
    end

endmodule // presettable_down_timer

/* tb_presettable_down_timer.sv */
`timescale 1ns/100ps
`include "timer_cfg.svh"
module tb_presettable_down_timer import timer_pkg::*;;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic        dbg = 1'b0, slp = 1'b0, last_ser = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  osc = 4'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, ser;
    wire  [2:0]  uf, irq;
    logic [32:0] exp_q[$];
    int          err_total = 0, total_checks = 0, cyc = 0;
    localparam int HALF [4] = '{20, 24, 16, 12};
    localparam int PER [4] = '{10, 12, 8, 6};
    presettable_down_timer i_dut (.ref_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(1'b1),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .internal_rc_oscillator_in(osc[0]), .low_speed_oscillator_in(osc[1]),
        .high_speed_oscillator_in(osc[2]), .external_clock_input_in(osc[3]),
        .event_count_input_in(3'h0), .debug_mode_in(dbg), .sleep_clock_stop_in(slp),
        .underflow_pulse_out(uf), .irq_out(irq), .serial_master_clock_out(ser));
    initial forever #2 clk = ~clk;
    // odd start offset keeps source edges away from the sampling edge
    for (genvar g = 0; g < 4; g++) begin : g_osc
        initial begin
            #1;
            forever #(HALF[g]) osc[g] = ~osc[g];
        end
    end
    task automatic chk(string what, logic [32:0] seen, logic [32:0] expv);
        total_checks++;
        if (seen !== expv) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, expv, seen);
        end
    endtask
    task automatic end_of_test();
        if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // idle edge after each transfer so no driver signal is assigned twice in one step
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(logic [7:0] a, logic [32:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task automatic wait_uf(int ch, output int n);
        n = 0;
        // outputs are sampled mid-cycle, away from the edge that launches them
        do begin
            @(negedge clk);
            n++;
        end while (uf[ch] !== 1'b1 && n < 3000);
        last_ser = ser;
        @(posedge clk);
        chk("uf_seen", 33'(n < 3000), 33'h1);
    endtask
    always @(posedge clk)
        if (psel && pen && !pwr && pready === 1'b1)
            chk("read", {pslverr, prdata}, exp_q.pop_front());
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        int n;
        int p;
        logic [1:0] d;
        logic [15:0] r;
        p = $urandom(32'h8a94_f660);
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int c = 0; c < 3; c++) begin
            rd(8'(c * 32 + 12), 33'h0_0000_ffff);
            rd(8'(c * 32 + 16), 33'h0_0000_ffff);
            rd(8'(c * 32), 33'h0_0000_0000);
        end
        foreach (HALF[i]) begin
            p = (i == 0) ? 8'h1c : (i == 1) ? 8'h80 : (i == 2) ? 8'h61 : 8'h7c;
            wr(8'(p), 32'hffff_ffff);
            rd(8'(p), 33'h1_0000_0000);
        end
        wr(8'h10, 32'h0000_0000);
        rd(8'h10, 33'h0_0000_ffff);
        for (int s = 0; s < 4; s++) begin
            d = 2'($urandom_range(2));
            r = 16'($urandom_range(3, 1));
            wr(8'h20, 32'({2'h0, d, 2'h0, 2'(s)}));
            wr(8'h2c, {16'h0000, r});
            wr(8'h28, 32'h0000_0103);
            wait_uf(1, n);
            chk("serial", 33'(last_ser), 33'h1);
            wait_uf(1, n);
            chk("period", 33'(n), 33'((r + 1) * (s == 3 ? 1 : 1 << d) * PER[s]));
            wr(8'h28, 32'h0000_0001);
        end
        wr(8'h24, 32'h0000_0001);
        wr(8'h2c, 32'h0000_0002);
        wr(8'h28, 32'h0000_0002);
        rd(8'h28, 33'h0_0000_0002);
        wr(8'h28, 32'h0000_0103);
        wait_uf(1, n);
        chk("serial", 33'(last_ser), 33'h0);
        repeat (60) @(posedge clk);
        rd(8'h28, 33'h0_0000_0001);
        rd(8'h30, 33'h0_0000_0002);
        wr(8'h00, 32'h0000_0003);
        wr(8'h0c, 32'h0000_0010);
        wr(8'h08, 32'h0000_0003);
        dbg <= 1'b1;
        wr(8'h08, 32'h0000_0101);
        repeat (60) @(posedge clk);
        rd(8'h10, 33'h0_0000_0010);
        dbg <= 1'b0;
        slp <= 1'b1;
        repeat (60) @(posedge clk);
        rd(8'h10, 33'h0_0000_0010);
        slp <= 1'b0;
        wait_uf(0, n);
        dbg <= 1'b1;
        wr(8'h00, 32'h0000_0103);
        wait_uf(0, n);
        dbg <= 1'b0;
        wr(8'h08, 32'h0000_0001);
        rd(8'h14, 33'h0_0000_0001);
        chk("irq", 33'(irq[0]), 33'h0);
        wr(8'h18, 32'h0000_0001);
        chk("irq", 33'(irq[0]), 33'h1);
        wr(8'h14, 32'h0000_0000);
        chk("irq", 33'(irq[0]), 33'h1);
        wr(8'h14, 32'h0000_0001);
        chk("irq", 33'(irq[0]), 33'h0);
        end_of_test();
    end
endmodule // tb_presettable_down_timer

/* timer_cfg.svh */
// What this block does
// - sixteen-bit down counter reloaded from reload value
// - two-bit field selects count clock source
// - divide non-external source by two to the divider
// - debug suspends counting unless debug run set
// - sleep clock stop halts channel, keeps state
// - source three counts external clock rising edges
// - preset copies reload; run starts counting
// - underflow pulse sets flag, clocks peripheral in repeat mode only
// - underflow period is reload plus one ticks
// - repeat mode reloads and keeps counting
// - one-shot reloads, stops, clears run bit
// - flag set on underflow, write-one clears
// - interrupt only when flag and enable set
// - three channels; channel one clocks serial
// - preset bit reads one until preset done
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
`define NUM_CH          3
`define SERIAL_CH       1
`define EVENT_CH_MASK   3'b000
`define NUM_SYNC        7
`define OFS_CLK         3'h0
`define OFS_MOD         3'h1
`define OFS_CTL         3'h2
`define OFS_TR          3'h3
`define OFS_TC          3'h4
`define OFS_INTF        3'h5
`define OFS_INTE        3'h6
`define REG_LAST        3'h6
`define BIT_DEBUG_RUN_ENABLE       8
`define DIV_LSB         4
`define BIT_RUN         8
`define BIT_PRESET      1
`define BIT_ENABLE      0
`define BIT_ONE_SHOT    0
`define BIT_FLAG        0
`define BIT_IRQ_EN      0
`define SRC_INTERNAL    2'h0
`define SRC_LOW_SPEED   2'h1
`define SRC_HIGH_SPEED  2'h2
`define SRC_EXTERNAL    2'h3
`define RESET_COUNT     16'hffff
`define ZERO_COUNT      16'h0000
`define ONE_COUNT       16'h0001
`define ALL_ONES_15     15'h7fff
`define ZERO_15         15'h0000
`define ONE_15          15'h0001
`endif

/* timer_monitor.sv */
`timescale 1ns/100ps
`include "timer_cfg.svh"
module timer_monitor (
    input wire logic              ref_clk_in,
    input wire logic              reset_n_in,
    input wire logic              psel_in,
    input wire logic              penable_in,
    input wire logic              pwrite_in,
    input wire logic [7:0]        paddr_in,
    input wire logic              pready_out,
    input wire logic              pslverr_out,
    input wire logic              sleep_clock_stop_in,
    input wire logic [`NUM_CH-1:0] underflow_pulse_out,
    input wire logic [`NUM_CH-1:0] irq_out,
    input wire logic              serial_master_clock_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    wire logic acc = psel_in && penable_in;
    wire logic wr = acc && pwrite_in;
    property p_ready; acc |-> pready_out; endproperty
    a_ready: assert property (p_ready) else $error("no zero wait answer");
    property p_err_phase; pslverr_out |-> acc; endproperty
    a_err_phase: assert property (p_err_phase) else $error("slave error outside access");
    property p_err_map; acc && (paddr_in[7] || paddr_in[1:0] != 2'h0) |-> pslverr_out; endproperty
    a_err_map: assert property (p_err_map) else $error("unmapped access not flagged");
    property p_serial; serial_master_clock_out |-> underflow_pulse_out[1]; endproperty
    a_serial: assert property (p_serial) else $error("serial clock without underflow");
    property p_pulse; underflow_pulse_out[0] |=> !underflow_pulse_out[0]; endproperty
    a_pulse: assert property (p_pulse) else $error("underflow pulse too long");
    property p_sleep; sleep_clock_stop_in [*3] |-> underflow_pulse_out == '0; endproperty
    a_sleep: assert property (p_sleep) else $error("underflow during sleep stop");
    property p_irq_rise;
        $rose(irq_out[0]) |-> $past(wr) or $past(underflow_pulse_out[0]) or
            ##[0:1] underflow_pulse_out[0];
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");
    property p_irq_fall; $fell(irq_out[0]) |-> $past(wr); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq cleared by itself");
endmodule // timer_monitor
bind presettable_down_timer timer_monitor i_mon (.ref_clk_in, .reset_n_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pready_out, .pslverr_out, .sleep_clock_stop_in,
    .underflow_pulse_out, .irq_out, .serial_master_clock_out);

/* timer_pkg.sv */
package timer_pkg;
    typedef struct packed {
        logic       debug_run_enable;
        logic [3:0] count_clock_divider;
        logic [1:0] count_clock_source;
        logic       one_shot_select;
        logic       channel_enable;
        logic       underflow_irq_enable;
        logic [15:0] reload_value;
    } chan_cfg_t;
    typedef struct packed {
        logic        run_control;
        logic        preset_busy;
        logic        underflow_flag;
        logic [15:0] counter_value;
    } chan_state_t;
endpackage
